// >>> tb_tile_status_config_regs.sv
`timescale 1ns/1ps
module tb_tile_status_config_regs
   import tsc_pkg::*;
;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic        core_clk = 1'b0;
   logic        srst, por, ps_wr, ps_rd, ps_rvalid;
   logic [7:0]  ps_num, processor_number;
   logic [31:0] ps_wdata, ps_rdata, target_addr, otp_sec_word;
   logic        event_take, target_valid, otp_sec_valid;
   logic [15:0] event_vector;
   logic        secure_override_pin, second_core_off_flag;
   logic        otp_poll_off_pin, boot_ram_pin, boot_jtag_pin;
   logic [1:0]  pll_strap_value;
   logic        all_threads_paused;
   logic [3:0]  osc_in, random_bits, otp_sector_lock;
   logic [7:0]  rgmii_tx_delay;
   logic        rgmii_tx_clk, rgmii_port_enable, lp_divider_active;
   logic        usb_utmi_select, ulpi_support_enable;
   logic        global_debug_block, jtag_tap_block, jtag_cfg_block;
   logic        otp_master_lock, fuse_redundancy_enable, otp_boot_force;
   int          fail_count = 0;
   int          compares = 0;

   always #5 core_clk = ~core_clk;

   tsc_status_regs tsc_status_regs_inst (
      .core_clk               (core_clk),
      .srst                   (srst),
      .por                    (por),
      .ps_wr                  (ps_wr),
      .ps_rd                  (ps_rd),
      .ps_num                 (ps_num),
      .ps_wdata               (ps_wdata),
      .ps_rdata               (ps_rdata),
      .ps_rvalid              (ps_rvalid),
      .event_take             (event_take),
      .event_vector           (event_vector),
      .target_addr            (target_addr),
      .target_valid           (target_valid),
      .otp_sec_valid          (otp_sec_valid),
      .otp_sec_word           (otp_sec_word),
      .processor_number       (processor_number),
      .secure_override_pin    (secure_override_pin),
      .second_core_off_flag   (second_core_off_flag),
      .otp_poll_off_pin       (otp_poll_off_pin),
      .boot_ram_pin           (boot_ram_pin),
      .boot_jtag_pin          (boot_jtag_pin),
      .pll_strap_value        (pll_strap_value),
      .all_threads_paused     (all_threads_paused),
      .osc_in                 (osc_in),
      .rgmii_tx_delay         (rgmii_tx_delay),
      .rgmii_tx_clk           (rgmii_tx_clk),
      .rgmii_port_enable      (rgmii_port_enable),
      .lp_divider_active      (lp_divider_active),
      .usb_utmi_select        (usb_utmi_select),
      .ulpi_support_enable    (ulpi_support_enable),
      .global_debug_block     (global_debug_block),
      .jtag_tap_block         (jtag_tap_block),
      .jtag_cfg_block         (jtag_cfg_block),
      .otp_master_lock        (otp_master_lock),
      .otp_sector_lock        (otp_sector_lock),
      .fuse_redundancy_enable (fuse_redundancy_enable),
      .otp_boot_force         (otp_boot_force),
      .random_bits            (random_bits)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] n, input logic [31:0] d);
      @(negedge core_clk);
      ps_wr = 1'b1;
      ps_num = n;
      ps_wdata = d;
      @(negedge core_clk);
      ps_wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] n, input logic [31:0] exp);
      @(negedge core_clk);
      ps_rd = 1'b1;
      ps_num = n;
      @(negedge core_clk);
      ps_rd = 1'b0;
      check("read valid", {31'h0, ps_rvalid}, 32'h00000001);
      check($sformatf("reg %h", n), ps_rdata, exp);
   endtask

   task automatic osc_pulses(input logic [3:0] m, input int cnt);
      repeat (cnt) begin
         @(negedge core_clk);
         osc_in = m;
         repeat (4) @(negedge core_clk);
         osc_in = 4'h0;
         repeat (4) @(negedge core_clk);
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      rd_chk(TSC_REG_VEC_BASE, 32'h00000000);
      rd_chk(TSC_REG_TILE_CTRL, 32'h00000000);
      rd_chk(TSC_REG_OSC_CTRL, 32'h00000000);
      rd_chk(8'h04, 32'h00000000);
      rd_chk(8'h00, 32'h00000000);
   endtask

   task automatic t_vector();
      wr(TSC_REG_VEC_BASE, 32'h5A5FFFFF);
      rd_chk(TSC_REG_VEC_BASE, 32'h5A5C0000);
      @(negedge core_clk);
      event_take = 1'b1;
      event_vector = 16'h1234;
      @(negedge core_clk);
      event_vector = 16'hABCD;
      check("event valid", {31'h0, target_valid}, 32'h00000001);
      check("event target", target_addr, 32'h5A5C1234);
      @(negedge core_clk);
      event_take = 1'b0;
      check("event target", target_addr, 32'h5A5CABCD);
      @(negedge core_clk);
      check("event valid", {31'h0, target_valid}, 32'h00000000);
   endtask

   task automatic t_tile_ctrl();
      wr(TSC_REG_TILE_CTRL, 32'hFFFFFFFF);
      rd_chk(TSC_REG_TILE_CTRL, 32'h03FFFF36);
      check("delay", {24'h0, rgmii_tx_delay}, 32'h000000FF);
      check("ctrl outs", {28'h0, rgmii_port_enable, usb_utmi_select,
            ulpi_support_enable, lp_divider_active}, 32'hE);
      all_threads_paused = 1'b1;
      repeat (3) @(negedge core_clk);
      check("lp paused", {31'h0, lp_divider_active}, 32'h1);
      all_threads_paused = 1'b0;
      wr(TSC_REG_TILE_CTRL, 32'h00000012);
      repeat (2) @(negedge core_clk);
      check("ctrl outs", {28'h0, rgmii_port_enable, usb_utmi_select,
            ulpi_support_enable, lp_divider_active}, 32'h3);
      wr(TSC_REG_TILE_CTRL, 32'h00000004);
      repeat (2) @(negedge core_clk);
      check("ctrl outs", {28'h0, rgmii_port_enable, usb_utmi_select,
            ulpi_support_enable, lp_divider_active}, 32'h4);
   endtask

   task automatic t_tx_clock();
      logic [31:0] h;
      int a;
      int b;
      int hi;
      a = -1;
      b = -1;
      hi = 0;
      // Divide ratio 6 written as 5
      wr(TSC_REG_TILE_CTRL, 32'h00000B00);
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < 32; i++) begin
         @(negedge core_clk);
         h[i] = rgmii_tx_clk;
      end
      for (int i = 1; i < 32; i++) begin
         if (h[i-1] === 1'b0 && h[i] === 1'b1) begin
            if (a < 0) a = i;
            else if (b < 0) b = i;
         end
      end
      for (int i = 0; i < 32; i++) begin
         if (i >= a && i < b && h[i] === 1'b1) hi++;
      end
      check("tx clk period", b - a, 32'd6);
      check("tx clk high", hi, 32'd3);
   endtask

   task automatic t_boot();
      processor_number = 8'hA5;
      secure_override_pin = 1'b1;
      second_core_off_flag = 1'b1;
      boot_ram_pin = 1'b1;
      pll_strap_value = 2'h2;
      repeat (4) @(negedge core_clk);
      wr(TSC_REG_BOOT_STATE, 32'hFFFFFFFF);
      rd_chk(TSC_REG_BOOT_STATE, 32'h00A5012A);
      secure_override_pin = 1'b0;
      second_core_off_flag = 1'b0;
      otp_poll_off_pin = 1'b1;
      boot_ram_pin = 1'b0;
      boot_jtag_pin = 1'b1;
      pll_strap_value = 2'h1;
      repeat (4) @(negedge core_clk);
      rd_chk(TSC_REG_BOOT_STATE, 32'h00A50015);
   endtask

   task automatic otp_load(input logic [31:0] w);
      @(negedge core_clk);
      otp_sec_valid = 1'b1;
      otp_sec_word = w;
      @(negedge core_clk);
      otp_sec_valid = 1'b0;
   endtask

   task automatic t_security();
      wr(TSC_REG_SECURITY, 32'hFFFFFFFF);
      rd_chk(TSC_REG_SECURITY, 32'h80005FB1);
      wr(TSC_REG_SECURITY, 32'h00000000);
      rd_chk(TSC_REG_SECURITY, 32'h80005FB1);
      otp_load(32'h00005281);
      rd_chk(TSC_REG_SECURITY, 32'h00005281);
      check("sec outs", {22'h0, global_debug_block, jtag_tap_block,
            jtag_cfg_block, otp_master_lock, otp_sector_lock,
            fuse_redundancy_enable, otp_boot_force}, 32'h34A);
      wr(TSC_REG_SECURITY, 32'h00000130);
      @(negedge core_clk);
      check("sec outs", {22'h0, global_debug_block, jtag_tap_block,
            jtag_cfg_block, otp_master_lock, otp_sector_lock,
            fuse_redundancy_enable, otp_boot_force}, 32'h085);
   endtask

   task automatic t_oscillators();
      wr(TSC_REG_OSC_CTRL, 32'hFFFFFFFF);
      rd_chk(TSC_REG_OSC_CTRL, 32'h00000003);
      wr(TSC_REG_OSC_CTRL, 32'h00000002);
      osc_pulses(4'hF, 5);
      wr(TSC_REG_OSC_CTRL, 32'h00000000);
      repeat (12) @(negedge core_clk);
      rd_chk(TSC_REG_OSC_COUNT0, 32'h00000005);
      check("random bits", {28'h0, random_bits}, 32'h3);
      wr(TSC_REG_OSC_CTRL, 32'h00000001);
      osc_pulses(4'hF, 3);
      wr(TSC_REG_OSC_CTRL, 32'h00000000);
      osc_pulses(4'hF, 2);
      repeat (12) @(negedge core_clk);
      rd_chk(TSC_REG_OSC_COUNT0, 32'h00000005);
      check("random bits", {28'h0, random_bits}, 32'hF);
      @(negedge core_clk);
      srst = 1'b1;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      wr(TSC_REG_OSC_COUNT0, 32'hFFFFFFFF);
      rd_chk(TSC_REG_OSC_COUNT0, 32'h00000005);
      rd_chk(TSC_REG_TILE_CTRL, 32'h00000000);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      {srst, por} = 2'b11;
      {ps_wr, ps_rd, event_take, otp_sec_valid} = 4'h0;
      ps_num = 8'h00;
      ps_wdata = 32'h00000000;
      event_vector = 16'h0000;
      otp_sec_word = 32'h00000000;
      processor_number = 8'h00;
      {secure_override_pin, second_core_off_flag, otp_poll_off_pin} = 3'h0;
      {boot_ram_pin, boot_jtag_pin, all_threads_paused} = 3'h0;
      pll_strap_value = 2'h0;
      osc_in = 4'h0;
      repeat (12) @(negedge core_clk);
      {srst, por} = 2'b00;
      t_reset_values();
      t_vector();
      t_tile_ctrl();
      t_tx_clock();
      t_boot();
      t_security();
      t_oscillators();
      stop_test();
   end

   initial begin
      repeat (10000) @(posedge core_clk);
      fail_count++;
      stop_test();
   end

endmodule

// >>> tsc_osc_counter.sv
`timescale 1ns/1ps
module tsc_osc_counter
   import tsc_pkg::*;
(
   // Clock and power-on clear
   input  wire logic                 core_clk,
   input  wire logic                 por,
   // Control
   input  wire logic                 run,
   // Oscillator pin
   input  wire logic                 osc_in,
   // Count
   output logic [TSC_CNT_W-1:0]      count
);

   typedef struct packed {
      logic                 s1;
      logic                 s2;
      logic                 s3;
      logic [TSC_CNT_W-1:0] cnt;
   } tsc_osc_s;

   tsc_osc_s st_r;
   tsc_osc_s st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = osc_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (run && st_r.s2 && !st_r.s3) begin
         st_nxt.cnt = st_r.cnt + 16'h0001;
      end
   end

   // Only power-on clears the count; system reset does not
   always_ff @(posedge core_clk) begin
      if (por) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign count = st_r.cnt;

   AST_OSC_HOLD: assert property (@(posedge core_clk)
      disable iff (por) !run [*3] |=> $stable(st_r.cnt))
      else $error("count moved while oscillator stopped");

endmodule

// >>> tsc_pkg.sv
package tsc_pkg;

   // -------------------------------------------------------------------
   // Register numbers
   // -------------------------------------------------------------------
   localparam logic [7:0] TSC_REG_VEC_BASE   = 8'h01;
   localparam logic [7:0] TSC_REG_TILE_CTRL  = 8'h02;
   localparam logic [7:0] TSC_REG_BOOT_STATE = 8'h03;
   localparam logic [7:0] TSC_REG_SECURITY   = 8'h05;
   localparam logic [7:0] TSC_REG_OSC_CTRL   = 8'h06;
   localparam logic [7:0] TSC_REG_OSC_COUNT0 = 8'h07;

   // -------------------------------------------------------------------
   // Writable masks and reset values
   // -------------------------------------------------------------------
   localparam logic [31:0] TSC_VEC_MASK  = 32'hFFFC0000;
   localparam logic [31:0] TSC_CTRL_MASK = 32'h03FFFF36;
   localparam logic [31:0] TSC_SEC_MASK  = 32'h80005FB1;
   localparam logic [31:0] TSC_OSC_MASK  = 32'h00000003;
   localparam logic [31:0] TSC_ZERO32    = 32'h00000000;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int TSC_VEC_LSB      = 18;
   localparam int TSC_VEC_W        = 14;
   localparam int TSC_ADDR_HALF    = 16;
   localparam int TSC_TXDLY_LSB    = 18;
   localparam int TSC_TXDLY_W      = 8;
   localparam int TSC_TXDIV_LSB    = 9;
   localparam int TSC_TXDIV_W      = 9;
   localparam int TSC_RGMII_EN_BIT = 8;
   localparam int TSC_DIV_DYN_BIT  = 5;
   localparam int TSC_DIV_EN_BIT   = 4;
   localparam int TSC_UTMI_BIT     = 2;
   localparam int TSC_ULPI_EN_BIT  = 1;
   localparam int TSC_BOOT_PROC_LSB = 16;
   localparam int TSC_BOOT_SECURE_BIT = 8;
   localparam int TSC_BOOT_CORE1_BIT  = 5;
   localparam int TSC_BOOT_NOPOLL_BIT = 4;
   localparam int TSC_BOOT_RAM_BIT    = 3;
   localparam int TSC_BOOT_JTAG_BIT   = 2;
   localparam int TSC_BOOT_PLL_LSB    = 0;
   localparam int TSC_SEC_LOCK_BIT    = 31;
   localparam int TSC_SEC_GDBG_BIT    = 14;
   localparam int TSC_SEC_MLOCK_BIT   = 12;
   localparam int TSC_SEC_SLOCK_LSB   = 8;
   localparam int TSC_SEC_RED_BIT     = 7;
   localparam int TSC_SEC_SBOOT_BIT   = 5;
   localparam int TSC_SEC_JCFG_BIT    = 4;
   localparam int TSC_SEC_JTAP_BIT    = 0;
   localparam int TSC_OSC_CORE_BIT    = 1;
   localparam int TSC_OSC_PERI_BIT    = 0;
   localparam int TSC_CNT_W           = 16;
   localparam int TSC_NUM_OSC         = 4;
   localparam int TSC_STRAP_W         = 7;

   // Pads a count into a read word, upper bits zero
   function automatic logic [31:0] tsc_pad16(input logic [15:0] v);
      tsc_pad16 = {16'h0000, v};
   endfunction

endpackage

// >>> tsc_status_regs.sv
`timescale 1ns/1ps
module tsc_status_regs
   import tsc_pkg::*;
(
   // Clock and resets
   input  wire logic                  core_clk,
   input  wire logic                  srst,
   input  wire logic                  por,
   // Status register access
   input  wire logic                  ps_wr,
   input  wire logic                  ps_rd,
   input  wire logic [7:0]            ps_num,
   input  wire logic [31:0]           ps_wdata,
   output logic [31:0]                ps_rdata,
   output logic                       ps_rvalid,
   // Event vectoring
   input  wire logic                  event_take,
   input  wire logic [15:0]           event_vector,
   output logic [31:0]                target_addr,
   output logic                       target_valid,
   // OTP security word
   input  wire logic                  otp_sec_valid,
   input  wire logic [31:0]           otp_sec_word,
   // Boot straps and tile identity
   input  wire logic [7:0]            processor_number,
   input  wire logic                  secure_override_pin,
   input  wire logic                  second_core_off_flag,
   input  wire logic                  otp_poll_off_pin,
   input  wire logic                  boot_ram_pin,
   input  wire logic                  boot_jtag_pin,
   input  wire logic [1:0]            pll_strap_value,
   // Thread state
   input  wire logic                  all_threads_paused,
   // Oscillator pins
   input  wire logic [TSC_NUM_OSC-1:0] osc_in,
   // Peripheral controls
   output logic [TSC_TXDLY_W-1:0]     rgmii_tx_delay,
   output logic                       rgmii_tx_clk,
   output logic                       rgmii_port_enable,
   output logic                       lp_divider_active,
   output logic                       usb_utmi_select,
   output logic                       ulpi_support_enable,
   // Security controls
   output logic                       global_debug_block,
   output logic                       jtag_tap_block,
   output logic                       jtag_cfg_block,
   output logic                       otp_master_lock,
   output logic [3:0]                 otp_sector_lock,
   output logic                       fuse_redundancy_enable,
   output logic                       otp_boot_force,
   // Random source
   output logic [TSC_NUM_OSC-1:0]     random_bits
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [31:0]             vec;
      logic [31:0]             ctrl;
      logic [31:0]             sec;
      logic [31:0]             osc;
      logic [TSC_STRAP_W-1:0]  strap_s1;
      logic [TSC_STRAP_W-1:0]  strap_s2;
      logic [31:0]             rdata;
      logic                    rvalid;
      logic [31:0]             taddr;
      logic                    tvalid;
      logic                    lp_act;
      logic                    tx_clk;
      logic [TSC_NUM_OSC-1:0]  rnd;
   } tsc_regs_s;

   tsc_regs_s                  st_r;
   tsc_regs_s                  st_nxt;
   logic [TSC_CNT_W-1:0]       counts [TSC_NUM_OSC];
   logic                       tx_clk_raw;
   logic [31:0]                boot_word;
   logic [TSC_STRAP_W-1:0]     strap_pins;

   // -------------------------------------------------------------------
   // Oscillator counters
   // -------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < TSC_NUM_OSC; gi++) begin : g_osc
         tsc_osc_counter u_cnt (
            .core_clk (core_clk),
            .por      (por),
            .run      ((gi < 2) ? st_r.osc[TSC_OSC_CORE_BIT]
                                : st_r.osc[TSC_OSC_PERI_BIT]),
            .osc_in   (osc_in[gi]),
            .count    (counts[gi])
         );
      end
   endgenerate

   tsc_tx_clk_gen u_txg (
      .core_clk (core_clk),
      .srst     (srst),
      .enable   (st_r.ctrl[TSC_RGMII_EN_BIT]),
      .div      (st_r.ctrl[TSC_TXDIV_LSB +: TSC_TXDIV_W]),
      .tx_clk   (tx_clk_raw)
   );

   // -------------------------------------------------------------------
   // Boot status word
   // -------------------------------------------------------------------
   assign strap_pins = {secure_override_pin, second_core_off_flag,
                        otp_poll_off_pin, boot_ram_pin, boot_jtag_pin,
                        pll_strap_value};

   always_comb begin
      boot_word = TSC_ZERO32;
      boot_word[TSC_BOOT_PROC_LSB +: 8]  = processor_number;
      boot_word[TSC_BOOT_SECURE_BIT]     = st_r.strap_s2[6];
      boot_word[TSC_BOOT_CORE1_BIT]      = st_r.strap_s2[5];
      boot_word[TSC_BOOT_NOPOLL_BIT]     = st_r.strap_s2[4];
      boot_word[TSC_BOOT_RAM_BIT]        = st_r.strap_s2[3];
      boot_word[TSC_BOOT_JTAG_BIT]       = st_r.strap_s2[2];
      boot_word[TSC_BOOT_PLL_LSB +: 2]   = st_r.strap_s2[1:0];
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      st_nxt          = st_r;
      st_nxt.strap_s1 = strap_pins;
      st_nxt.strap_s2 = st_r.strap_s1;
      st_nxt.rvalid   = 1'b0;
      st_nxt.tvalid   = 1'b0;
      st_nxt.tx_clk   = tx_clk_raw;
      for (int i = 0; i < TSC_NUM_OSC; i++) begin
         st_nxt.rnd[i] = counts[i][0];
      end

      if (ps_wr) begin
         case (ps_num)
            TSC_REG_VEC_BASE:  st_nxt.vec = ps_wdata & TSC_VEC_MASK;
            TSC_REG_TILE_CTRL: st_nxt.ctrl = ps_wdata & TSC_CTRL_MASK;
            TSC_REG_SECURITY: begin
               if (!st_r.sec[TSC_SEC_LOCK_BIT]) begin
                  st_nxt.sec = ps_wdata & TSC_SEC_MASK;
               end
            end
            TSC_REG_OSC_CTRL:  st_nxt.osc = ps_wdata & TSC_OSC_MASK;
            default: ;
         endcase
      end

      // OTP copy takes precedence over a software write
      if (otp_sec_valid) begin
         st_nxt.sec = otp_sec_word & TSC_SEC_MASK;
      end

      if (ps_rd) begin
         st_nxt.rvalid = 1'b1;
         case (ps_num)
            TSC_REG_VEC_BASE:   st_nxt.rdata = st_r.vec;
            TSC_REG_TILE_CTRL:  st_nxt.rdata = st_r.ctrl;
            TSC_REG_BOOT_STATE: st_nxt.rdata = boot_word;
            TSC_REG_SECURITY:   st_nxt.rdata = st_r.sec;
            TSC_REG_OSC_CTRL:   st_nxt.rdata = st_r.osc;
            TSC_REG_OSC_COUNT0: st_nxt.rdata = tsc_pad16(counts[0]);
            default:            st_nxt.rdata = TSC_ZERO32;
         endcase
      end

      if (event_take) begin
         st_nxt.taddr  = {st_r.vec[31:TSC_ADDR_HALF], event_vector};
         st_nxt.tvalid = 1'b1;
      end

      st_nxt.lp_act = st_r.ctrl[TSC_DIV_EN_BIT] &&
                      (!st_r.ctrl[TSC_DIV_DYN_BIT] ||
                       all_threads_paused);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign ps_rdata               = st_r.rdata;
   assign ps_rvalid              = st_r.rvalid;
   assign target_addr            = st_r.taddr;
   assign target_valid           = st_r.tvalid;
   assign rgmii_tx_delay         =
      st_r.ctrl[TSC_TXDLY_LSB +: TSC_TXDLY_W];
   assign rgmii_tx_clk           = st_r.tx_clk;
   assign rgmii_port_enable      = st_r.ctrl[TSC_RGMII_EN_BIT];
   assign lp_divider_active      = st_r.lp_act;
   assign usb_utmi_select        = st_r.ctrl[TSC_UTMI_BIT];
   assign ulpi_support_enable    = st_r.ctrl[TSC_ULPI_EN_BIT];
   assign global_debug_block     = st_r.sec[TSC_SEC_GDBG_BIT];
   assign jtag_tap_block         = st_r.sec[TSC_SEC_JTAP_BIT];
   assign jtag_cfg_block         = st_r.sec[TSC_SEC_JCFG_BIT];
   assign otp_master_lock        = st_r.sec[TSC_SEC_MLOCK_BIT];
   assign otp_sector_lock        = st_r.sec[TSC_SEC_SLOCK_LSB +: 4];
   assign fuse_redundancy_enable = st_r.sec[TSC_SEC_RED_BIT];
   assign otp_boot_force         = st_r.sec[TSC_SEC_SBOOT_BIT];
   assign random_bits            = st_r.rnd;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   AST_VEC_TARGET: assert property (@(posedge core_clk)
      disable iff (srst) event_take |=> target_valid &&
         target_addr[15:0] == $past(event_vector) &&
         target_addr[31:16] == $past(st_r.vec[31:16]))
      else $error("target address not formed from base and vector");

   AST_VEC_RSVD: assert property (@(posedge core_clk)
      disable iff (srst) ps_rd && ps_num == TSC_REG_VEC_BASE
         |=> ps_rdata[17:0] == 18'h00000)
      else $error("vector base reserved bits not zero");

   AST_CTRL_WR: assert property (@(posedge core_clk)
      disable iff (srst) ps_wr && ps_num == TSC_REG_TILE_CTRL |=>
         rgmii_tx_delay == $past(ps_wdata[25:18]) &&
         rgmii_port_enable == $past(ps_wdata[8]) &&
         usb_utmi_select == $past(ps_wdata[2]) &&
         ulpi_support_enable == $past(ps_wdata[1]))
      else $error("control write not reflected on outputs");

   AST_CTRL_RST: assert property (@(posedge core_clk)
      srst |=> rgmii_tx_delay == 8'h00 && !rgmii_port_enable &&
         !lp_divider_active)
      else $error("control fields not cleared by reset");

   AST_LP_DYN: assert property (@(posedge core_clk)
      disable iff (srst) st_r.ctrl[4] && st_r.ctrl[5] &&
         !all_threads_paused |=> !lp_divider_active)
      else $error("dynamic divider active with running threads");

   AST_LP_STATIC: assert property (@(posedge core_clk)
      disable iff (srst) st_r.ctrl[4] && !st_r.ctrl[5]
         |=> lp_divider_active)
      else $error("static divider not active");

   AST_SEC_LOCK: assert property (@(posedge core_clk)
      disable iff (srst) st_r.sec[31] && !otp_sec_valid
         |=> $stable(st_r.sec))
      else $error("locked security register changed");

   AST_OTP_LOAD: assert property (@(posedge core_clk)
      disable iff (srst) otp_sec_valid |=>
         otp_boot_force == $past(otp_sec_word[5]) &&
         otp_sector_lock == $past(otp_sec_word[11:8]) &&
         jtag_tap_block == $past(otp_sec_word[0]))
      else $error("security word not loaded from OTP");

   AST_COUNT_RD: assert property (@(posedge core_clk)
      disable iff (srst) ps_rd && ps_num == TSC_REG_OSC_COUNT0 |=>
         ps_rvalid && ps_rdata == {16'h0000, $past(counts[0])})
      else $error("oscillator count read wrong");

   AST_UNMAPPED: assert property (@(posedge core_clk)
      disable iff (srst) ps_rd && ps_num == 8'h04 |=>
         ps_rdata == 32'h00000000)
      else $error("unmapped register read not zero");

   COV_EVENT: cover property (@(posedge core_clk) disable iff (srst)
      event_take ##1 target_valid);
   COV_LOCKED_WR: cover property (@(posedge core_clk) disable iff (srst)
      st_r.sec[31] && ps_wr && ps_num == TSC_REG_SECURITY);
   COV_OSC_RUN: cover property (@(posedge core_clk) disable iff (srst)
      st_r.osc[1] ##1 !st_r.osc[1] ##[10:20] ps_rd &&
         ps_num == TSC_REG_OSC_COUNT0);
   COV_DYN: cover property (@(posedge core_clk) disable iff (srst)
      st_r.ctrl[5] && lp_divider_active);

endmodule

// >>> tsc_tx_clk_gen.sv
`timescale 1ns/1ps
module tsc_tx_clk_gen
   import tsc_pkg::*;
(
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   srst,
   // Control
   input  wire logic                   enable,
   input  wire logic [TSC_TXDIV_W-1:0] div,
   // Generated clock
   output logic                        tx_clk
);

   typedef struct packed {
      logic [TSC_TXDIV_W-1:0] cnt;
      logic                   clk;
   } tsc_txg_s;

   tsc_txg_s st_r;
   tsc_txg_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (!enable) begin
         st_nxt = '0;
      end else begin
         st_nxt.cnt = (st_r.cnt >= div) ? '0 : st_r.cnt + 9'h001;
         if (st_r.cnt == div) begin
            st_nxt.clk = 1'b1;
         end else if (st_r.cnt == (div >> 1)) begin
            st_nxt.clk = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tx_clk = st_r.clk;

   AST_TXCLK_RISE: assert property (@(posedge core_clk)
      disable iff (srst) enable && st_r.cnt == div |=> tx_clk)
      else $error("tx clock did not rise at divider match");

endmodule
